// [common/offset_power_pkg.sv]
package offset_power_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [6:0] IDX_NV_CONF = 7'h70;
  localparam logic [6:0] IDX_ACC_OFF_X = 7'h71;
  localparam logic [6:0] IDX_ACC_OFF_Y = 7'h72;
  localparam logic [6:0] IDX_ACC_OFF_Z = 7'h73;
  localparam logic [6:0] IDX_GYR_OFF_X_LOW = 7'h74;
  localparam logic [6:0] IDX_GYR_OFF_Y_LOW = 7'h75;
  localparam logic [6:0] IDX_GYR_OFF_Z_LOW = 7'h76;
  localparam logic [6:0] IDX_GYR_OFF_HIGH = 7'h77;
  localparam logic [6:0] IDX_POWER_CONFIGURATION = 7'h7c;
  localparam logic [6:0] IDX_CMD = 7'h7e;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int NUM_AXES = 3;

  // reset values
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [7:0] POWER_CONFIGURATION_RST = 8'h03;

  // field positions
  localparam int ACC_OFF_EN_BIT = 3;
  localparam int GYR_OFF_EN_BIT = 6;
  localparam int GYR_GAIN_EN_BIT = 7;
  localparam int APS_BIT = 0;
  localparam int FIFO_WAKE_BIT = 1;
  localparam int FUP_BIT = 2;
  localparam int POWER_CONFIGURATION_W = 3;
  localparam int GYR_HIGH_W = 2;

  // commands
  localparam logic [7:0] CMD_NVM_PROG = 8'ha0;

  // gain correction is a signed fraction in units of 2^-GAIN_SHIFT
  localparam int GAIN_SHIFT = 10;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

  typedef struct packed {
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } axes_t;

  typedef struct packed {
    logic acc_off_en;
    logic [7:0] gyr_off_high;
    logic [7:0] gyr_off_z_low;
    logic [7:0] gyr_off_y_low;
    logic [7:0] gyr_off_x_low;
    logic [7:0] acc_off_z;
    logic [7:0] acc_off_y;
    logic [7:0] acc_off_x;
  } nvm_image_t;

endpackage : offset_power_pkg

// [rtl/offset_power_config_regs.sv]
// Function
// R1 - three 8-bit read/write accelerometer offset registers for X, Y and Z sit at consecutive addresses and reset to zero.
// R2 - each gyro offset is 10 bits: low byte in its own register, upper two bits in adjacent pairs of a shared register, X lowest.
// R3 - with the gyro offset enable bit 6 set, the gyro offsets are added to filtered and unfiltered gyro data, otherwise not.
// R4 - with the gain enable bit 7 set, gyro sensitivity gain compensation is applied to the output, otherwise not.
// R5 - all offset and enable registers are non-volatile backed and reset to zero.
// R6 - the power configuration register resets to 0x03, so advanced power save is on after reset.
// R7 - with the FIFO self wake-up bit set, FIFO reads in low power mode are allowed after a FIFO interrupt, otherwise refused.
// R8 - with accelerometer offset enable bit 3 set, accel offsets are added to filtered and unfiltered accel data.
// R9 - writing 0xa0 to the command register copies the non-volatile backed registers into non-volatile storage.
// R10 - accel 8-bit and gyro 10-bit offsets are treated as two's-complement values.
`timescale 1ns/1ps

module offset_power_config_regs (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [offset_power_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [offset_power_pkg::DATA_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [offset_power_pkg::DATA_W-1:0] o_readdata,
  output logic [1:0] o_response,
  output logic o_waitrequest,
  // sensor data in
  input wire offset_power_pkg::axes_t i_acc_raw,
  input wire offset_power_pkg::axes_t i_acc_filt,
  input wire offset_power_pkg::axes_t i_gyr_raw,
  input wire offset_power_pkg::axes_t i_gyr_filt,
  input wire logic [7:0] i_gyr_gain_corr,
  // compensated sensor data out
  output offset_power_pkg::axes_t o_acc_raw,
  output offset_power_pkg::axes_t o_acc_filt,
  output offset_power_pkg::axes_t o_gyr_raw,
  output offset_power_pkg::axes_t o_gyr_filt,
  // power control
  input wire logic i_low_power_mode,
  input wire logic i_fifo_int,
  input wire logic i_fifo_rd_req,
  output logic o_fifo_rd_grant,
  output logic o_adv_power_save,
  output logic o_fifo_self_wake_up,
  output logic o_fast_power_up,
  // non-volatile store
  output logic o_nvm_prog,
  output offset_power_pkg::nvm_image_t o_nvm_image
);
  import offset_power_pkg::*;

  logic [NUM_AXES-1:0][7:0] acc_off_ff;
  logic [NUM_AXES-1:0][7:0] gyr_low_ff;
  logic [7:0] gyr_high_ff;
  logic acc_off_en_ff;
  logic [POWER_CONFIGURATION_W-1:0] power_configuration_ff;
  logic ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] resp_ff;
  logic fifo_fired_ff;
  logic nvm_prog_ff;
  nvm_image_t nvm_image_ff;

  logic [6:0] idx;
  logic hit;
  logic wr_take;
  logic [7:0] wbyte;
  logic [DATA_W-1:0] nxt_rdata;
  logic gyr_off_en;
  logic gyr_gain_en;

  assign idx = i_address[ADDR_W-1:2];
  assign wbyte = i_writedata[7:0];
  assign gyr_off_en = gyr_high_ff[GYR_OFF_EN_BIT];
  assign gyr_gain_en = gyr_high_ff[GYR_GAIN_EN_BIT];

  // ---------------- bus slave ----------------
  always_comb begin
    hit = 1'b0;
    if (i_address[1:0] == 2'h0) begin
      case (idx)
        IDX_NV_CONF, IDX_ACC_OFF_X, IDX_ACC_OFF_Y, IDX_ACC_OFF_Z,
        IDX_GYR_OFF_X_LOW, IDX_GYR_OFF_Y_LOW, IDX_GYR_OFF_Z_LOW,
        IDX_GYR_OFF_HIGH, IDX_POWER_CONFIGURATION, IDX_CMD: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // one wait state on every access keeps read data a flip-flop output
  assign o_waitrequest = (i_read | i_write) & ~ack_ff;
  assign wr_take = i_write & ack_ff & hit & i_byteenable[0];

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_read | i_write) & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (idx)
      IDX_NV_CONF: nxt_rdata[ACC_OFF_EN_BIT] = acc_off_en_ff;
      IDX_ACC_OFF_X: nxt_rdata[7:0] = acc_off_ff[0];
      IDX_ACC_OFF_Y: nxt_rdata[7:0] = acc_off_ff[1];
      IDX_ACC_OFF_Z: nxt_rdata[7:0] = acc_off_ff[2];
      IDX_GYR_OFF_X_LOW: nxt_rdata[7:0] = gyr_low_ff[0];
      IDX_GYR_OFF_Y_LOW: nxt_rdata[7:0] = gyr_low_ff[1];
      IDX_GYR_OFF_Z_LOW: nxt_rdata[7:0] = gyr_low_ff[2];
      IDX_GYR_OFF_HIGH: nxt_rdata[7:0] = gyr_high_ff;
      IDX_POWER_CONFIGURATION: nxt_rdata[POWER_CONFIGURATION_W-1:0] = power_configuration_ff;
      // command register always reads back zero
      default: nxt_rdata = '0;
    endcase
    if (!hit) begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
      resp_ff <= RESP_OKAY;
    end else if ((i_read | i_write) & ~ack_ff) begin
      rdata_ff <= i_read ? nxt_rdata : '0;
      resp_ff <= hit ? RESP_OKAY : RESP_DECODE_ERR;
    end
  end

  assign o_readdata = rdata_ff;
  assign o_response = resp_ff;

  // ---------------- offset and enable registers ----------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      acc_off_ff <= {NUM_AXES{OFFSET_RST}}; // R1 R5
    end else if (wr_take) begin
      case (idx)
        IDX_ACC_OFF_X: acc_off_ff[0] <= wbyte; // R1
        IDX_ACC_OFF_Y: acc_off_ff[1] <= wbyte; // R1
        IDX_ACC_OFF_Z: acc_off_ff[2] <= wbyte; // R1
        default: acc_off_ff <= acc_off_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      gyr_low_ff <= {NUM_AXES{OFFSET_RST}}; // R5
      gyr_high_ff <= OFFSET_RST; // R5
      acc_off_en_ff <= OFFSET_RST[ACC_OFF_EN_BIT];
    end else if (wr_take) begin
      case (idx)
        IDX_GYR_OFF_X_LOW: gyr_low_ff[0] <= wbyte; // R2
        IDX_GYR_OFF_Y_LOW: gyr_low_ff[1] <= wbyte; // R2
        IDX_GYR_OFF_Z_LOW: gyr_low_ff[2] <= wbyte; // R2
        IDX_GYR_OFF_HIGH: gyr_high_ff <= wbyte; // R2
        IDX_NV_CONF: acc_off_en_ff <= wbyte[ACC_OFF_EN_BIT]; // R8
        default: gyr_high_ff <= gyr_high_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      power_configuration_ff <= POWER_CONFIGURATION_RST[POWER_CONFIGURATION_W-1:0]; // R6
    end else if (wr_take && idx == IDX_POWER_CONFIGURATION) begin
      power_configuration_ff <= wbyte[POWER_CONFIGURATION_W-1:0];
    end
  end

  assign o_adv_power_save = power_configuration_ff[APS_BIT]; // R6
  assign o_fifo_self_wake_up = power_configuration_ff[FIFO_WAKE_BIT];
  assign o_fast_power_up = power_configuration_ff[FUP_BIT];

  // ---------------- non-volatile programming ----------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      nvm_prog_ff <= 1'b0;
      nvm_image_ff <= '0;
    end else begin
      nvm_prog_ff <= wr_take && idx == IDX_CMD && wbyte == CMD_NVM_PROG; // R9
      if (wr_take && idx == IDX_CMD && wbyte == CMD_NVM_PROG) begin
        nvm_image_ff <= {acc_off_en_ff, gyr_high_ff, gyr_low_ff[2],
                         gyr_low_ff[1], gyr_low_ff[0], acc_off_ff[2],
                         acc_off_ff[1], acc_off_ff[0]}; // R9 R5
      end
    end
  end

  assign o_nvm_prog = nvm_prog_ff;
  assign o_nvm_image = nvm_image_ff;

  // ---------------- fifo access in low power ----------------
  // set wins over clear so an interrupt at the mode change is kept
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      fifo_fired_ff <= 1'b0;
    end else if (i_fifo_int) begin
      fifo_fired_ff <= 1'b1;
    end else if (!i_low_power_mode) begin
      fifo_fired_ff <= 1'b0;
    end
  end

  assign o_fifo_rd_grant = i_fifo_rd_req & (~i_low_power_mode |
    (o_fifo_self_wake_up & fifo_fired_ff)); // R7

  // ---------------- offset and gain datapath ----------------
  function automatic logic [SAMPLE_W-1:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff) begin
      sat16 = 16'h7fff;
    end else if (v < -18'sh08000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[SAMPLE_W-1:0];
    end
  endfunction : sat16

  logic [NUM_AXES-1:0][SAMPLE_W-1:0] acc_raw_a, acc_filt_a;
  logic [NUM_AXES-1:0][SAMPLE_W-1:0] gyr_raw_a, gyr_filt_a;
  logic [NUM_AXES-1:0][SAMPLE_W-1:0] acc_raw_ff, acc_filt_ff;
  logic [NUM_AXES-1:0][SAMPLE_W-1:0] gyr_raw_ff, gyr_filt_ff;

  assign acc_raw_a = i_acc_raw;
  assign acc_filt_a = i_acc_filt;
  assign gyr_raw_a = i_gyr_raw;
  assign gyr_filt_a = i_gyr_filt;

  genvar a;
  generate
    for (a = 0; a < NUM_AXES; a++) begin : g_axis
      logic signed [17:0] acc_off_s;
      logic signed [17:0] gyr_off_s;
      logic signed [17:0] gain_raw, gain_filt;
      logic signed [23:0] prod_raw, prod_filt;
      logic [9:0] gyr_off10;

      assign gyr_off10 = {gyr_high_ff[2*a+1 -: GYR_HIGH_W],
                          gyr_low_ff[a]}; // R2
      assign acc_off_s = acc_off_en_ff ?
        18'(signed'(acc_off_ff[a])) : 18'sh0; // R8 R10
      assign gyr_off_s = gyr_off_en ?
        18'(signed'(gyr_off10)) : 18'sh0; // R3 R10
      assign prod_raw = signed'(gyr_raw_a[a]) * signed'(i_gyr_gain_corr);
      assign prod_filt = signed'(gyr_filt_a[a]) * signed'(i_gyr_gain_corr);
      // gain applied before the offset so the offset is not rescaled
      assign gain_raw = 18'(signed'(gyr_raw_a[a])) + (gyr_gain_en ?
        18'(prod_raw >>> GAIN_SHIFT) : 18'sh0); // R4
      assign gain_filt = 18'(signed'(gyr_filt_a[a])) + (gyr_gain_en ?
        18'(prod_filt >>> GAIN_SHIFT) : 18'sh0); // R4

      always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
          acc_raw_ff[a] <= '0;
          acc_filt_ff[a] <= '0;
          gyr_raw_ff[a] <= '0;
          gyr_filt_ff[a] <= '0;
        end else begin
          acc_raw_ff[a] <= sat16(18'(signed'(acc_raw_a[a])) + acc_off_s);
          acc_filt_ff[a] <= sat16(18'(signed'(acc_filt_a[a])) + acc_off_s);
          gyr_raw_ff[a] <= sat16(gain_raw + gyr_off_s); // R3
          gyr_filt_ff[a] <= sat16(gain_filt + gyr_off_s); // R3
        end
      end
    end
  endgenerate

  assign o_acc_raw = acc_raw_ff;
  assign o_acc_filt = acc_filt_ff;
  assign o_gyr_raw = gyr_raw_ff;
  assign o_gyr_filt = gyr_filt_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  logic small_acc, small_gyr;
  assign small_acc = acc_filt_a[0][15:13] == 3'h0 ||
                     acc_filt_a[0][15:13] == 3'h7;
  assign small_gyr = gyr_raw_a[0][15:13] == 3'h0 ||
                     gyr_raw_a[0][15:13] == 3'h7;

  AST_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest || !(i_read || i_write))
    else $error("waitrequest held longer than one cycle");

  AST_ACC_WRITE: assert property (wr_take && idx == IDX_ACC_OFF_Y // R1
    |=> acc_off_ff[1] == $past(wbyte) ##1 o_readdata[31:8] == 24'h0)
    else $error("accel y offset not stored");

  AST_GYR_OFF_ADD: assert property (gyr_off_en && !gyr_gain_en && small_gyr // R3
    |=> signed'(o_gyr_raw.x) == signed'($past(gyr_raw_a[0])) +
        signed'({{6{$past(gyr_high_ff[1])}}, $past(gyr_high_ff[1:0]),
        $past(gyr_low_ff[0])}))
    else $error("gyro offset not added");

  // the release edge still resets the flops, so reset must be sampled high
  AST_GYR_PASS: assert property (i_resetn && !gyr_off_en && !gyr_gain_en // R4
    |=> o_gyr_filt == $past(i_gyr_filt))
    else $error("gyro data altered while disabled");

  AST_ACC_OFF_ADD: assert property (acc_off_en_ff && small_acc // R8
    |=> signed'(o_acc_filt.x) == signed'($past(acc_filt_a[0])) +
        signed'({{8{$past(acc_off_ff[0][7])}}, $past(acc_off_ff[0])}))
    else $error("accel offset not added");

  AST_PWR_WRITE: assert property (wr_take && idx == IDX_POWER_CONFIGURATION // R6
    |=> o_adv_power_save == $past(wbyte[APS_BIT]) &&
        o_fast_power_up == $past(wbyte[FUP_BIT]))
    else $error("power configuration not stored");

  AST_FIFO_REFUSE: assert property (i_low_power_mode && // R7
    (!o_fifo_self_wake_up || !fifo_fired_ff) |-> !o_fifo_rd_grant)
    else $error("fifo read granted in low power mode");

  AST_NVM_PROG: assert property (wr_take && idx == IDX_CMD && // R9
    wbyte == CMD_NVM_PROG |=> o_nvm_prog &&
    o_nvm_image.acc_off_x == $past(acc_off_ff[0]) ##1 !o_nvm_prog)
    else $error("nvm programming pulse or image wrong");

  AST_DECODE_ERR: assert property ((i_read || i_write) && o_waitrequest &&
    !hit |=> o_response == RESP_DECODE_ERR && o_readdata == '0)
    else $error("unmapped access not flagged");

  AST_ACC_PASS: assert property (i_resetn && !acc_off_en_ff // R8
    |=> o_acc_raw == $past(i_acc_raw))
    else $error("accel data altered while offset disabled");

  AST_GYR_HIGH_STORE: assert property (wr_take && // R2
    idx == IDX_GYR_OFF_HIGH |=> gyr_high_ff == $past(wbyte))
    else $error("gyro high bits not stored");

  AST_LP_GRANT: assert property (i_fifo_rd_req && i_low_power_mode && // R7
    o_fifo_self_wake_up && fifo_fired_ff |-> o_fifo_rd_grant)
    else $error("fifo read refused after interrupt");

  AST_CMD_READ_ZERO: assert property (i_read && o_waitrequest && // R9
    idx == IDX_CMD |=> o_readdata == '0)
    else $error("command register read not zero");

  COV_ACC_WRITE: cover property (wr_take && idx == IDX_ACC_OFF_X);
  COV_NVM_PROG: cover property (o_nvm_prog);
  COV_LP_GRANT: cover property (o_fifo_rd_grant && i_low_power_mode);
  COV_GAIN_ON: cover property (gyr_gain_en && gyr_off_en);
  COV_DECODE_ERR: cover property (o_response == RESP_DECODE_ERR);

endmodule : offset_power_config_regs

// [tb/offset_power_config_regs_tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module offset_power_config_regs_tb_top;
  import offset_power_pkg::*;

  logic i_clk_sys, i_resetn, i_read, i_write, o_waitrequest;
  logic [ADDR_W-1:0] i_address;
  logic [DATA_W-1:0] i_writedata, o_readdata;
  logic [3:0] i_byteenable;
  logic [1:0] o_response;
  logic [7:0] i_gyr_gain_corr;
  axes_t i_acc_raw, i_acc_filt, i_gyr_raw, i_gyr_filt;
  axes_t o_acc_raw, o_acc_filt, o_gyr_raw, o_gyr_filt;
  logic i_low_power_mode, i_fifo_int, i_fifo_rd_req, o_fifo_rd_grant;
  logic o_adv_power_save, o_fifo_self_wake_up, o_fast_power_up, o_nvm_prog;
  nvm_image_t o_nvm_image;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] shadow [9];
  logic [56:0] img;
  axes_t ar, af, gr, gf;
  logic [7:0] gc;
  // order: nv conf, accel x y z, gyro low x y z, gyro high, power conf
  localparam logic [6:0] IDX [9] = '{IDX_NV_CONF, IDX_ACC_OFF_X,
    IDX_ACC_OFF_Y, IDX_ACC_OFF_Z, IDX_GYR_OFF_X_LOW, IDX_GYR_OFF_Y_LOW,
    IDX_GYR_OFF_Z_LOW, IDX_GYR_OFF_HIGH, IDX_POWER_CONFIGURATION};
  localparam logic [7:0] MSK [9] = '{8'h08, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h07};

  offset_power_config_regs i_dut (
    .i_clk_sys, .i_resetn, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable, .o_readdata, .o_response, .o_waitrequest,
    .i_acc_raw, .i_acc_filt, .i_gyr_raw, .i_gyr_filt, .i_gyr_gain_corr,
    .o_acc_raw, .o_acc_filt, .o_gyr_raw, .o_gyr_filt,
    .i_low_power_mode, .i_fifo_int, .i_fifo_rd_req, .o_fifo_rd_grant,
    .o_adv_power_save, .o_fifo_self_wake_up, .o_fast_power_up,
    .o_nvm_prog, .o_nvm_image
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // all drives are non-blocking, so at a rising edge the pre-edge values
  // are seen; the request is dropped at the edge that samples it low
  task automatic bus(input logic wr, input logic [6:0] idx,
                     input logic [1:0] lo, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_address <= {idx, lo};
    i_writedata <= {24'($urandom()), d};
    i_write <= wr;
    i_read <= ~wr;
    @(posedge i_clk_sys);
    while (o_waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge i_clk_sys);
    end
    rd = o_readdata;
    rs = o_response;
    i_read <= 1'b0;
    i_write <= 1'b0;
    `CHK("wait states", 1, n)
  endtask : bus

  task automatic fstep(input logic lp, input logic fi, input logic rq);
    @(posedge i_clk_sys);
    i_low_power_mode <= lp;
    i_fifo_int <= fi;
    i_fifo_rd_req <= rq;
    @(negedge i_clk_sys);
  endtask : fstep

  function automatic logic [15:0] sat(input int v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return 16'(v);
  endfunction : sat

  function automatic logic [15:0] exp_acc(input logic [15:0] x, input int a);
    int v = $signed(x);
    if (shadow[0][ACC_OFF_EN_BIT]) v += $signed(shadow[1+a]);
    return sat(v);
  endfunction : exp_acc

  // gyro samples are multiples of 1024 so the gain product has no rounding
  function automatic logic [15:0] exp_gyr(input logic [15:0] x, input int a);
    int v = $signed(x);
    logic [9:0] off = {shadow[7][2*a +: 2], shadow[4+a]};
    if (shadow[7][GYR_GAIN_EN_BIT]) v += (v / 1024) * $signed(gc);
    if (shadow[7][GYR_OFF_EN_BIT]) v += $signed(off);
    return sat(v);
  endfunction : exp_gyr

  function automatic axes_t gsample();
    axes_t s;
    for (int a = 0; a < 3; a++) begin
      s[a*16 +: 16] = 16'((int'($urandom_range(48)) - 24) * 1024);
    end
    return s;
  endfunction : gsample

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    failures++;
    give_verdict();
  end

  initial begin
    i_resetn = 1'b0;
    {i_read, i_write, i_address, i_writedata} = '0;
    i_byteenable = 4'hf;
    {i_acc_raw, i_acc_filt, i_gyr_raw, i_gyr_filt, i_gyr_gain_corr} = '0;
    {i_low_power_mode, i_fifo_int, i_fifo_rd_req} = '0;
    void'($urandom(32'hb6448315));
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    for (int r = 0; r < 9; r++) begin
      bus(1'b0, IDX[r], 2'h0, 8'h00);
      `CHK("reset value", {24'h0, r == 8 ? POWER_CONFIGURATION_RST : OFFSET_RST}, rd)
    end
    `CHK("power outputs", 3'b011, {o_fast_power_up, o_fifo_self_wake_up, o_adv_power_save})
    for (int r = 0; r < 9; r++) begin
      shadow[r] = 8'($urandom());
      bus(1'b1, IDX[r], 2'h0, shadow[r]);
      shadow[r] = shadow[r] & MSK[r];
      bus(1'b0, IDX[r], 2'h0, 8'h00);
      `CHK("read back", {24'h0, shadow[r]}, rd)
    end
    `CHK("power outputs", shadow[8][2:0], {o_fast_power_up, o_fifo_self_wake_up, o_adv_power_save})
    // byte lane 0 off: the write must vanish but still answer okay
    i_byteenable <= 4'he;
    bus(1'b1, IDX[1], 2'h0, ~shadow[1]);
    `CHK("masked write resp", RESP_OKAY, rs)
    i_byteenable <= 4'hf;
    bus(1'b1, IDX[1], 2'h1, ~shadow[1]);
    `CHK("misaligned resp", RESP_DECODE_ERR, rs)
    bus(1'b0, IDX[1], 2'h0, 8'h00);
    `CHK("accel x kept", {24'h0, shadow[1]}, rd)
    bus(1'b0, 7'h00, 2'h0, 8'h00);
    `CHK("unmapped resp", RESP_DECODE_ERR, rs)
    `CHK("unmapped data", 32'h0, rd)
    bus(1'b0, IDX_CMD, 2'h0, 8'h00);
    `CHK("command reads zero", 32'h0, rd)
    for (int c = 0; c < 4; c++) begin
      shadow[0] = {4'h0, c[0], 3'h0};
      shadow[7] = {c[1], c[0], 6'($urandom())};
      bus(1'b1, IDX[0], 2'h0, shadow[0]);
      bus(1'b1, IDX[7], 2'h0, shadow[7]);
      for (int i = 0; i < 8; i++) begin
        ar = 48'({$urandom(), $urandom()});
        af = 48'({$urandom(), $urandom()});
        if (i == 0) ar[15:0] = 16'h7ffe;
        if (i == 1) af[31:16] = 16'h8001;
        gr = gsample();
        gf = gsample();
        gc = 8'($urandom());
        @(posedge i_clk_sys);
        {i_acc_raw, i_acc_filt, i_gyr_raw, i_gyr_filt} <= {ar, af, gr, gf};
        i_gyr_gain_corr <= gc;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        for (int a = 0; a < 3; a++) begin
          `CHK("acc raw", exp_acc(ar[a*16 +: 16], a), o_acc_raw[a*16 +: 16])
          `CHK("acc filt", exp_acc(af[a*16 +: 16], a), o_acc_filt[a*16 +: 16])
          `CHK("gyr raw", exp_gyr(gr[a*16 +: 16], a), o_gyr_raw[a*16 +: 16])
          `CHK("gyr filt", exp_gyr(gf[a*16 +: 16], a), o_gyr_filt[a*16 +: 16])
        end
      end
    end
    img = {shadow[0][3], shadow[7], shadow[6], shadow[5], shadow[4],
           shadow[3], shadow[2], shadow[1]};
    bus(1'b1, IDX_CMD, 2'h0, CMD_NVM_PROG);
    @(negedge i_clk_sys);
    `CHK("nvm pulse", 1'b1, o_nvm_prog)
    `CHK("nvm image", img, o_nvm_image)
    @(negedge i_clk_sys);
    `CHK("nvm pulse end", 1'b0, o_nvm_prog)
    bus(1'b1, IDX_CMD, 2'h0, 8'hb0);
    @(negedge i_clk_sys);
    `CHK("nvm other cmd", 1'b0, o_nvm_prog)
    bus(1'b1, IDX_POWER_CONFIGURATION, 2'h0, 8'h02);
    fstep(1'b0, 1'b0, 1'b1);
    `CHK("grant active", 1'b1, o_fifo_rd_grant)
    fstep(1'b1, 1'b0, 1'b1);
    `CHK("grant low power", 1'b0, o_fifo_rd_grant)
    fstep(1'b1, 1'b1, 1'b1);
    `CHK("grant same cycle", 1'b0, o_fifo_rd_grant)
    fstep(1'b1, 1'b0, 1'b1);
    `CHK("grant after int", 1'b1, o_fifo_rd_grant)
    bus(1'b1, IDX_POWER_CONFIGURATION, 2'h0, 8'h01);
    @(negedge i_clk_sys);
    `CHK("grant wake off", 1'b0, o_fifo_rd_grant)
    // second reset in mid-run, with a fired interrupt still remembered
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(negedge i_clk_sys);
    `CHK("grant after reset", 1'b0, o_fifo_rd_grant)
    bus(1'b0, IDX_POWER_CONFIGURATION, 2'h0, 8'h00);
    `CHK("power_configuration rereset", {24'h0, POWER_CONFIGURATION_RST}, rd)
    bus(1'b0, IDX_GYR_OFF_HIGH, 2'h0, 8'h00);
    `CHK("gyro high rereset", 32'h0, rd)
    give_verdict();
  end
endmodule : offset_power_config_regs_tb_top
